// ### bench/clear_ctrl_model.sv
// Model of the enclosing system logic that drives the enable clear.
`timescale 1ns/1ps

module clear_ctrl_model (
    input  wire logic       sys_clk,
    input  wire logic       sample_enable,
    output logic            enable_clear,
    output logic            filter_reset,
    output logic [7:0]      accum_count
);
    logic clear_seen;

    // -------------------------------------------------
    // Clear driver
    // -------------------------------------------------
    // Starts low so that no clear overlaps the reset.
    initial enable_clear = 1'b0;

    // Raises the clear for len cycles, changing it just after an edge.
    // The caller waits afterwards, so invalid data after release is tolerated.
    task automatic clear_for(input int len);
        @(posedge sys_clk);
        #1 enable_clear = 1'b1;
        repeat (len) @(posedge sys_clk);
        #1 enable_clear = 1'b0;
    endtask : clear_for

    // -------------------------------------------------
    // Far-side filter reset and accumulation counter
    // -------------------------------------------------
    // The far-side polyphase filter gets a one-cycle reset right after each release,
    // otherwise its phase would stay scrambled by the jump of the enables.
    // The accumulation counter restarts with the clear and only counts extracted enables.
    always_ff @(posedge sys_clk) begin
        clear_seen   <= enable_clear;
        filter_reset <= clear_seen && !enable_clear;
        if (enable_clear) begin
            accum_count <= 8'h00;
        end else if (sample_enable) begin
            accum_count <= accum_count + 8'h01;
        end
    end
endmodule : clear_ctrl_model

// ### bench/multirate_monitor.sv
// Checker for the enable restart and hold behaviour of the datapath.
`timescale 1ns/1ps

module multirate_monitor
    import multirate_pkg::*;
#(
    parameter int SLOW_DIV  = RATE_SLOW_DIV,
    parameter int FRAME_DIV = RATE_FRAME_DIV
) (
    input wire logic                       sys_clk,
    input wire logic                       rst_n,
    input wire logic                       enable_clear,
    input wire logic [DATA_W-1:0]          slow_in,
    input wire logic                       quarter_rate_enable,
    input wire logic                       frame_rate_enable,
    input wire sample_t                    down_last_out,
    input wire logic [DATA_W-1:0]          up_copy_out,
    input wire logic [CHANNELS*DATA_W-1:0] time_slot_demultiplexer_out,
    input wire logic [CHANNELS*DATA_W-1:0] serial_to_parallel_converter_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // -------------------------------------------------
    // Sequences
    // -------------------------------------------------
    // Exported enables lag the internal ones, so release counts use DIV+1.
    sequence release_q;
        $fell(enable_clear) ##1 !enable_clear [*4];
    endsequence
    sequence release_f;
        $fell(enable_clear) ##1 !enable_clear [*8] ##1 !enable_clear [*8];
    endsequence
    // Four edges of clear let every pipeline stage settle before checking.
    sequence quiet;
        enable_clear [*4];
    endsequence

    // -------------------------------------------------
    // Assertions
    // -------------------------------------------------
    quarter_restart_a: assert property (release_q |=> quarter_rate_enable)
        else $error("quarter enable not one period after clear release");
    frame_restart_a: assert property (release_f |=> frame_rate_enable)
        else $error("frame enable not one period after clear release");
    clear_quiet_a: assert property (enable_clear [*3] |-> !quarter_rate_enable && !frame_rate_enable)
        else $error("enable pulse while clear held");
    quarter_gap_a: assert property (quarter_rate_enable |=> !quarter_rate_enable [*3])
        else $error("quarter enable closer than four cycles");
    quarter_period_a: assert property (!enable_clear ##1 (quarter_rate_enable && !enable_clear)
                                       ##1 !enable_clear [*3] |=> quarter_rate_enable)
        else $error("quarter enable missed its period");
    frame_align_a: assert property (frame_rate_enable |-> quarter_rate_enable)
        else $error("frame enable not aligned with quarter enable");
    copy_wire_a: assert property (up_copy_out == $past(slow_in))
        else $error("copy up-sampler output differs from slow input");
    down_hold_a: assert property (quiet |-> $stable(down_last_out.data))
        else $error("down-sampler changed during clear");
    demux_hold_a: assert property (quiet |-> $stable(time_slot_demultiplexer_out))
        else $error("demultiplexer changed during clear");
    s2p_hold_a: assert property (quiet |-> $stable(serial_to_parallel_converter_out))
        else $error("deserialiser changed during clear");
endmodule : multirate_monitor

bind multirate_datapath multirate_monitor #(
    .SLOW_DIV  (SLOW_DIV),
    .FRAME_DIV (FRAME_DIV)
) i_mon (
    .sys_clk                          (sys_clk),
    .rst_n                            (rst_n),
    .enable_clear                     (enable_clear),
    .slow_in                          (slow_in),
    .quarter_rate_enable              (quarter_rate_enable),
    .frame_rate_enable                (frame_rate_enable),
    .down_last_out                    (down_last_out),
    .up_copy_out                      (up_copy_out),
    .time_slot_demultiplexer_out      (time_slot_demultiplexer_out),
    .serial_to_parallel_converter_out (serial_to_parallel_converter_out)
);

// ### bench/testbench.sv
// Self-checking testbench for the multirate datapath.
`timescale 1ns/1ps

module testbench;
    import multirate_pkg::*;
    logic sys_clk;
    logic rst_n;
    wire logic enable_clear;
    logic [DATA_W-1:0] fast_in, slow_in;
    logic [CHANNELS*DATA_W-1:0] parallel_in, dmx, s2p, dmx0, s2p0;
    logic [2:0] shift_addr;
    logic q, f;
    sample_t dl, df, mx, uz, ps;
    logic [7:0] acc;
    logic frst;
    logic [DATA_W-1:0] uc, addressable_shift_register, dl0, asr0;
    int num_errors, cmp_count;

    clear_ctrl_model i_ctrl (.sys_clk(sys_clk), .sample_enable(q), .enable_clear(enable_clear),
        .filter_reset(frst), .accum_count(acc));
    multirate_datapath #(.SLOW_DIV(4), .FRAME_DIV(16), .DEPTH(8)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .enable_clear(enable_clear), .fast_in(fast_in),
        .slow_in(slow_in), .parallel_in(parallel_in), .shift_addr(shift_addr),
        .quarter_rate_enable(q), .frame_rate_enable(f), .down_last_out(dl), .down_first_out(df),
        .up_copy_out(uc), .up_zero_out(uz), .mux_out(mx), .time_slot_demultiplexer_out(dmx),
        .parallel_to_serial_converter_out(ps), .serial_to_parallel_converter_out(s2p),
        .addressable_shift_register_out(addressable_shift_register));

    // -------------------------------------------------
    // Shared tasks
    // -------------------------------------------------
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Counts edges until the chosen enable shows; bounded so a dead generator fails.
    task automatic count_to(input bit frame, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while (!(frame ? f : q) && n < 40);
    endtask : count_to

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    // -------------------------------------------------
    // Scenarios
    // -------------------------------------------------
    task automatic scen_restart;
        int n;
        i_ctrl.clear_for(3);
        count_to(0, n);
        check("quarter restart", n, 5);
        count_to(0, n);
        check("quarter period", n, 4);
        check("accumulate restart", acc, 8'h01);
        i_ctrl.clear_for(5);
        @(posedge sys_clk);
        #1 check("filter reset", frst, 1'b1);
        count_to(1, n);
        check("frame restart", n + 1, 17);
        count_to(1, n);
        check("frame period", n, 16);
    endtask : scen_restart

    // Inputs change mid-clear; held outputs must ignore them, the wire must not.
    task automatic scen_hold;
        int k;
        fork
            i_ctrl.clear_for(20);
            begin
                repeat (5) @(posedge sys_clk);
                #1 {dl0, dmx0, s2p0, asr0} = {dl.data, dmx, s2p, addressable_shift_register};
                slow_in = 16'h5a5a;
                fast_in = 16'hc3c3;
                @(posedge sys_clk);
                #1 check("copy wire", uc, 16'h5a5a);
                repeat (8) @(posedge sys_clk);
                #1 check("down hold", dl.data, dl0);
                check("demux hold", dmx, dmx0);
                check("s2p hold", s2p, s2p0);
                check("shift hold", addressable_shift_register, asr0);
            end
        join
        count_to(0, k);
        repeat (4) @(posedge sys_clk);
        #1 check("down update", dl.data, 16'hc3c3);
        for (k = 0; k < 80 && addressable_shift_register !== 16'h5a5a; k++)
            @(posedge sys_clk);
        #1 check("shift resume", addressable_shift_register, 16'h5a5a);
        // Eight slow enables must push the new sample down to the deepest tap.
        shift_addr = 3'h7;
        repeat (32) @(posedge sys_clk);
        #1 check("shift depth", addressable_shift_register, 16'h5a5a);
    endtask : scen_hold

    // The first-value sampler keeps its own phase straight through a clear.
    task automatic scen_first;
        for (int k = 0; k < 8; k++) begin
            @(posedge sys_clk);
            #1 if (df.valid === 1'b1) break;
        end
        fork
            i_ctrl.clear_for(6);
            for (int j = 0; j < 4; j++) begin
                repeat (4) @(posedge sys_clk);
                #1 check("first phase", df.valid, 1'b1);
                check("first data", df.data, 16'hc3c3);
            end
        join
    endtask : scen_first

    // The clear starts after the last channel of a frame, so a zero gap must follow release.
    task automatic scen_mux;
        int n;
        logic [4:0] seen;
        logic [3:0] seen_p;
        seen = '0;
        seen_p = '0;
        parallel_in = 64'h8888_7777_6666_5555;
        count_to(1, n);
        repeat (12) @(posedge sys_clk);
        i_ctrl.clear_for(7);
        for (int i = 1; i <= 40; i++) begin
            @(posedge sys_clk);
            #1 for (int c = 0; c < 4; c++) begin
                if (mx.data === parallel_in[c*16 +: 16]) seen[c] = 1'b1;
                if (ps.data === parallel_in[c*16 +: 16]) seen_p[c] = 1'b1;
            end
            if (mx.data === 16'h0000) seen[4] = 1'b1;
            if (i == 31) check("p2s hold", ps, {1'b0, parallel_in[63:48]});
        end
        check("mux lanes and zero", seen, 5'h1f);
        check("p2s lanes", seen_p, 4'hf);
        check("demux lanes", dmx, {4{16'h5a5a}});
        check("s2p lanes", s2p, {4{16'h5a5a}});
        count_to(0, n);
        check("zero insert sample", uz, {1'b1, 16'h5a5a});
        @(posedge sys_clk);
        #1 check("zero insert zero", uz, {1'b1, 16'h0000});
        @(posedge sys_clk);
        #1 check("zero insert hold", uz, {1'b0, 16'h0000});
    endtask : scen_mux

    // -------------------------------------------------
    // Clock, reset, sequence and watchdog
    // -------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (3000) @(posedge sys_clk);
        num_errors++;
        final_report();
    end

    initial begin
        {num_errors, cmp_count} = '0;
        rst_n = 1'b0;
        fast_in = 16'h1234;
        slow_in = 16'h0000;
        parallel_in = 64'h4444_3333_2222_1111;
        shift_addr = 3'h0;
        repeat (8) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (40) @(posedge sys_clk);
        scen_restart();
        scen_hold();
        scen_first();
        scen_mux();
        final_report();
    end
endmodule : testbench

// ### logic/enable_generator.sv
// Periodic clock-enable generator that restarts when cleared.
`timescale 1ns/1ps

module enable_generator #(
    parameter int DIV = 4
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic enable_clear,
    output logic      enable_pulse
);

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] count;

    // -----------------------------------------------------------------
    // Counter
    // -----------------------------------------------------------------
    // While cleared the count holds at zero, so the first pulse lands one full period after release.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (enable_clear) begin
            count <= '0;
        end else if (count == LAST) begin
            count <= '0;
        end else begin
            count <= count + CW'(1);
        end
    end

    // Pulse is registered; it fires in the cycle after the count reaches LAST, at the same edge as the count wraps to zero.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_pulse <= 1'b0;
        end else begin
            enable_pulse <= !enable_clear && (count == LAST);
        end
    end

endmodule : enable_generator

// ### logic/multirate_datapath.sv
// Multirate datapath with clearable enable generators and rate-changing elements.
//
// Contract
// - One clock, periodic enables per slower rate.
// - Enable clear resets all enable generators.
// - Generators restart count on clear release.
// - Rate changers tolerate the sampling phase jump.
// - Unsynchronised elements realign on first enable, except the first-value down-sampler.
// - Last-value down-sampler holds until new enable.
// - First-value down-sampler never realigns after clear.
// - Copy up-sampler registers the slow input every cycle.
// - Zero-insert up-sampler holds last output until enable.
// - Multiplexer finishes channels, drives zero, realigns.
// - Demultiplexer holds outputs until next frame enable.
// - Serialiser finishes words, holds last, restarts.
// - Deserialiser holds on clear, realigns after release.
// - Shift register keeps contents, then resumes shifting.
`timescale 1ns/1ps

module multirate_datapath
    import multirate_pkg::*;
#(
    parameter int SLOW_DIV  = RATE_SLOW_DIV,
    parameter int FRAME_DIV = RATE_FRAME_DIV,
    parameter int DEPTH     = SHIFT_DEPTH
) (
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    input  wire logic                         enable_clear,
    input  wire logic [DATA_W-1:0]            fast_in,
    input  wire logic [DATA_W-1:0]            slow_in,
    input  wire logic [CHANNELS*DATA_W-1:0]   parallel_in,
    input  wire logic [$clog2(SHIFT_DEPTH)-1:0] shift_addr,
    output logic                              quarter_rate_enable,
    output logic                              frame_rate_enable,
    output sample_t                           down_last_out,
    output sample_t                           down_first_out,
    output logic [DATA_W-1:0]                 up_copy_out,
    output sample_t                           up_zero_out,
    output sample_t                           mux_out,
    output logic [CHANNELS*DATA_W-1:0]        time_slot_demultiplexer_out,
    output sample_t                           parallel_to_serial_converter_out,
    output logic [CHANNELS*DATA_W-1:0]        serial_to_parallel_converter_out,
    output logic [DATA_W-1:0]                 addressable_shift_register_out
);

    localparam int CH_W = $clog2(CHANNELS);
    localparam logic [CH_W-1:0] CH_LAST = CH_W'(CHANNELS - 1);

    logic              ce_slow;
    logic              ce_frame;
    logic [CH_W-1:0]   mux_slot;
    logic              mux_active;
    logic [CH_W-1:0]   ser_slot;
    conv_state_t       ser_state;
    logic [CH_W-1:0]   des_slot;
    logic              des_aligned;
    logic [DATA_W-1:0] des_shadow [CHANNELS];
    logic [CH_W-1:0]   dmx_slot;
    logic              dmx_aligned;
    logic [DATA_W-1:0] shift_mem [DEPTH];
    logic [CH_W-1:0]   first_phase;
    logic              up_phase;

    // -----------------------------------------------------------------
    // Enable generation
    // -----------------------------------------------------------------
    // Each slower rate gets its own generator off the single system clock.
    enable_generator #(.DIV(SLOW_DIV)) u_slow_enable (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .enable_clear (enable_clear),
        .enable_pulse (ce_slow)
    );

    enable_generator #(.DIV(FRAME_DIV)) u_frame_enable (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .enable_clear (enable_clear),
        .enable_pulse (ce_frame)
    );

    // Enables are exported registered, one cycle behind the internal pulses.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            quarter_rate_enable <= 1'b0;
            frame_rate_enable   <= 1'b0;
        end else begin
            quarter_rate_enable <= ce_slow;
            frame_rate_enable   <= ce_frame;
        end
    end

    // -----------------------------------------------------------------
    // Down-samplers and up-samplers
    // -----------------------------------------------------------------
    // Last-value sampler: only the enable moves it, so a clear simply holds it.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            down_last_out <= '0;
        end else begin
            down_last_out.valid <= ce_slow;
            if (ce_slow) begin
                down_last_out.data <= fast_in;
            end
        end
    end

    // First-value sampler runs its own free phase counter that the clear never touches,
    // so its frame stays misaligned after a clear. Left this way to match the hardware.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_phase    <= '0;
            down_first_out <= '0;
        end else begin
            first_phase          <= first_phase + CH_W'(1);
            down_first_out.valid <= (first_phase == '0);
            if (first_phase == '0) begin
                down_first_out.data <= fast_in;
            end
        end
    end

    // Copy up-sampler has no state; registered only so the output comes off a flop.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_copy_out <= DATA_RESET;
        end else begin
            up_copy_out <= slow_in;
        end
    end

    // Zero-insert up-sampler: sample on the slow enable, zero on the next fast step, then hold.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_phase    <= 1'b0;
            up_zero_out <= '0;
        end else begin
            up_zero_out.valid <= ce_slow || up_phase;
            if (ce_slow) begin
                up_zero_out.data <= slow_in;
                up_phase         <= 1'b1;
            end else if (up_phase) begin
                up_zero_out.data <= DATA_RESET;
                up_phase         <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // Time-division multiplexer and demultiplexer
    // -----------------------------------------------------------------
    // Multiplexer steps one channel per slow enable; the frame enable restarts at channel 0.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mux_slot   <= '0;
            mux_active <= 1'b0;
            mux_out    <= '0;
        end else if (ce_frame) begin
            mux_slot     <= CH_W'(1);
            mux_active   <= 1'b1;
            mux_out.data <= parallel_in[0 +: DATA_W];
            mux_out.valid <= 1'b1;
        end else if (ce_slow && mux_active) begin
            mux_out.data  <= parallel_in[mux_slot*DATA_W +: DATA_W];
            mux_out.valid <= 1'b1;
            mux_slot      <= mux_slot + CH_W'(1);
            mux_active    <= (mux_slot != CH_LAST);
        end else if (ce_slow) begin
            mux_out.data  <= DATA_RESET;
            mux_out.valid <= 1'b0;
        end else begin
            mux_out.valid <= 1'b0;
        end
    end

    // Demultiplexer waits for a frame enable after clear before writing any channel.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dmx_slot                    <= '0;
            dmx_aligned                 <= 1'b0;
            time_slot_demultiplexer_out <= '0;
        end else if (enable_clear) begin
            dmx_aligned <= 1'b0;
        end else if (ce_frame) begin
            time_slot_demultiplexer_out[0 +: DATA_W] <= slow_in;
            dmx_slot    <= CH_W'(1);
            dmx_aligned <= 1'b1;
        end else if (ce_slow && dmx_aligned) begin
            time_slot_demultiplexer_out[dmx_slot*DATA_W +: DATA_W] <= slow_in;
            dmx_slot <= dmx_slot + CH_W'(1);
        end
    end

    // -----------------------------------------------------------------
    // Serial converters
    // -----------------------------------------------------------------
    // Serialiser finishes the word in flight across a clear, then holds the last word.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_state                        <= CONV_IDLE;
            ser_slot                         <= '0;
            parallel_to_serial_converter_out <= '0;
        end else begin
            parallel_to_serial_converter_out.valid <= 1'b0;
            case (ser_state)
                CONV_IDLE, CONV_HOLD: begin
                    if (ce_frame) begin
                        parallel_to_serial_converter_out <= '{1'b1, parallel_in[0 +: DATA_W]};
                        ser_slot  <= CH_W'(1);
                        ser_state <= CONV_RUN;
                    end
                end
                CONV_RUN: begin
                    if (ce_slow) begin
                        parallel_to_serial_converter_out <= '{1'b1, parallel_in[ser_slot*DATA_W +: DATA_W]};
                        ser_slot <= ser_slot + CH_W'(1);
                        if (ser_slot == CH_LAST) begin
                            ser_state <= CONV_HOLD;
                        end
                    end
                end
                default: begin
                    ser_state <= CONV_IDLE;
                end
            endcase
        end
    end

    // Deserialiser collects into a shadow and publishes on the frame enable; clear freezes the output.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            des_slot    <= '0;
            des_aligned <= 1'b0;
            for (int i = 0; i < CHANNELS; i++) begin
                des_shadow[i] <= DATA_RESET;
            end
        end else if (enable_clear) begin
            des_slot    <= '0;
            des_aligned <= 1'b0;
        end else if (ce_slow) begin
            des_shadow[des_slot] <= slow_in;
            des_slot             <= des_slot + CH_W'(1);
            des_aligned          <= des_aligned || (des_slot == CH_LAST);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_to_parallel_converter_out <= '0;
        end else if (ce_frame && des_aligned && !enable_clear) begin
            for (int i = 0; i < CHANNELS; i++) begin
                serial_to_parallel_converter_out[i*DATA_W +: DATA_W] <= des_shadow[i];
            end
        end
    end

    // -----------------------------------------------------------------
    // Addressable shift register
    // -----------------------------------------------------------------
    // Contents are kept through a clear; shifting resumes on the next slow enable.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                shift_mem[i] <= DATA_RESET;
            end
        end else if (ce_slow) begin
            shift_mem[0] <= slow_in;
            for (int i = 1; i < DEPTH; i++) begin
                shift_mem[i] <= shift_mem[i-1];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            addressable_shift_register_out <= DATA_RESET;
        end else begin
            addressable_shift_register_out <= shift_mem[shift_addr];
        end
    end

endmodule : multirate_datapath

// ### logic/multirate_pkg.sv
// Package with constants and carrier types for the multirate enable block.
package multirate_pkg;

    // ------------------------------------------------------------------
    // Rates and widths
    // ------------------------------------------------------------------
    localparam int          RATE_SLOW_DIV  = 4;
    localparam int          RATE_FRAME_DIV = 16;
    localparam int          DATA_W         = 16;
    localparam int          CHANNELS       = 4;
    localparam int          SHIFT_DEPTH    = 8;
    localparam logic [15:0] DATA_RESET     = 16'h0000;

    // One sample and its enable travelling together.
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } sample_t;

    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_RUN,
        CONV_HOLD
    } conv_state_t;

endpackage : multirate_pkg
